// >>> include/hb_seq_pkg.sv
/*
  Package for the half-bridge sequencer: register map, field positions,
  reset values, timing constants and carrier structs.
  Assumes a 125 MHz system clock and a 32-bit classic Wishbone slave port.
*/
package hb_seq_pkg;

  // System clock
  localparam int unsigned CLK_HZ = 125000000;

  // Slow timebase for the long timers, 1 kHz tick
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;

  // Long timer figures in milliseconds
  localparam int unsigned RESTART_DELAY_MS = 100;
  localparam int unsigned SETTLE_MS = 50;
  localparam int unsigned RESTART_DELAY_TICKS = RESTART_DELAY_MS * TICK_HZ / 1000;
  localparam int unsigned SETTLE_TICKS = SETTLE_MS * TICK_HZ / 1000;

  // Stop propagation delay in microseconds, rounded down to cycles
  localparam int unsigned STOP_DELAY_US = 20;
  localparam int unsigned STOP_DELAY_CYC = STOP_DELAY_US * (CLK_HZ / 1000000);

  // Low-side matching delay in system clock cycles
  localparam int unsigned MATCH_DELAY_CYC = 2;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CLR_FAULT_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;

  // Status register fields
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_DELAY_BIT = 1;
  localparam int ST_SETTLE_BIT = 2;
  localparam int ST_GOOD_BIT = 3;
  localparam int ST_SINK_BIT = 4;
  localparam int ST_PHASE_BIT = 5;
  localparam int ST_DISCH_BIT = 6;

  // Comparator results from the analog front end
  typedef struct packed {
    logic cap_full;
    logic cap_empty;
    logic sense_above_on;
    logic sense_above_latch;
    logic high_side_ok;
  } cmp_t;

  // Switch and drive commands to the analog front end
  typedef struct packed {
    logic charge_en;
    logic capacitor_discharge_sink;
    logic hysteresis_sink;
    logic timing_resistor_ground;
    logic drive_low;
    logic drive_high;
  } drv_t;

endpackage : hb_seq_pkg

// >>> logic/half_bridge_sequencer.sv
/*
  Half-bridge sequencer: oscillator phase control, dead time, restart
  delay, settling one-shot, fault latch and complementary drive outputs,
  with a classic Wishbone register slave.
  Assumes comparator inputs are asynchronous to I_CLOCK and that the supply
  undervoltage detector drives I_SRST.
*/
// Design decisions made here: the Wishbone slave port and the register addresses.
// Overview of operation
// - Divide-by-two toggle per oscillator cycle
// - Upper threshold stops charge, starts discharge
// - Both drives off during discharge
// - Empty capacitor ends discharge, restarts charge
// - Oscillator off during restart delay
// - Ground timing resistor pin during delay
// - Hysteresis sink on below turn-on
// - Sink off while window good
// - Sink forced on 50 ms after reset release
// - After one-shot, comparator decides sink
// - Latch threshold sets fault latch
// - Fault held until sense drops below turn-on or a clear-fault write
// - High-side lockout inhibits high drive
// - Low-side pulse first after restart
// - Matching delay on low-side path
// - Fixed 100 ms delay before switching
// - Sense below threshold clears fault latch
// - Drives stop about 20 us after stop
module half_bridge_sequencer #(
  // Cycles per slow tick; a bench may shorten it to reach the oscillator
  parameter int unsigned TICK_DIV = hb_seq_pkg::TICK_DIV
) (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire hb_seq_pkg::cmp_t I_CMP,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output hb_seq_pkg::drv_t O_DRV
);

  typedef enum logic [1:0] {ST_DELAY, ST_CHARGE, ST_DISCHARGE, ST_STOPPED} osc_state_t;

  // Two-flop synchronisers for the comparator bundle
  hb_seq_pkg::cmp_t meta_reg;
  hb_seq_pkg::cmp_t cmp_reg;
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      meta_reg <= '0;
      cmp_reg <= '0;
    end
    else
    begin
      meta_reg <= I_CMP;
      cmp_reg <= meta_reg;
    end
  end

  // State registers
  osc_state_t state_reg, state_next;
  logic phase_reg, phase_next;
  logic fault_reg, fault_next;
  logic [16:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic [7:0] delay_reg, delay_next;
  logic delay_run_reg, delay_run_next;
  logic [7:0] settle_reg, settle_next;
  logic settle_run_reg, settle_run_next;
  logic [11:0] stop_reg, stop_next;
  logic good_prev_reg, good_prev_next;
  logic run_prev_reg, run_prev_next;
  logic [hb_seq_pkg::MATCH_DELAY_CYC-1:0] low_pipe_reg, low_pipe_next;
  logic [hb_seq_pkg::MATCH_DELAY_CYC-1:0] high_pipe_reg, high_pipe_next;
  hb_seq_pkg::drv_t drv_reg, drv_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] rdat_reg, rdat_next;
  logic ack_reg, ack_next;

  logic sense_good;
  logic restart_evt;
  logic stop_hold;
  logic wb_req;
  logic clr_fault_wr;
  logic running;

  // Helper terms
  always_comb
  begin
    wb_req = I_WB_CYC && I_WB_STB && !ack_reg;
    clr_fault_wr = wb_req && I_WB_WE && (I_WB_ADR == hb_seq_pkg::ADDR_CTRL) && I_WB_SEL[0]
      && I_WB_DAT[hb_seq_pkg::CTRL_CLR_FAULT_BIT];
    // Brownout good only once the settle one-shot has finished
    sense_good = cmp_reg.sense_above_on && !settle_run_reg;
    // Stop requests are filtered for the propagation delay
    stop_hold = (stop_reg >= 12'(hb_seq_pkg::STOP_DELAY_CYC));
    running = ctrl_reg[hb_seq_pkg::CTRL_RUN_BIT] && !fault_reg && !stop_hold;
    // Restart on brownout becoming good or run enable rising
    restart_evt = (sense_good && !good_prev_reg)
      || (ctrl_reg[hb_seq_pkg::CTRL_RUN_BIT] && !run_prev_reg);
  end

  // Next-state logic for timers, fault latch and oscillator
  always_comb
  begin
    div_next = div_reg + 17'd1;
    tick_next = 1'b0;
    // Divider is 17 bits wide, so TICK_DIV must not exceed 131072
    if (div_reg == 17'(TICK_DIV - 1))
    begin
      div_next = '0;
      tick_next = 1'b1;
    end
    good_prev_next = sense_good;
    run_prev_next = ctrl_reg[hb_seq_pkg::CTRL_RUN_BIT];

    // Stop filter: count while sense is low, reset when good
    stop_next = stop_reg;
    if (cmp_reg.sense_above_on || settle_run_reg || delay_run_reg)
      stop_next = '0;
    else if (!stop_hold)
      stop_next = stop_reg + 12'd1;

    // Fault latch: set wins over any clear
    fault_next = fault_reg;
    if (cmp_reg.sense_above_latch)
      fault_next = 1'b1;
    else if (!cmp_reg.sense_above_on || clr_fault_wr)
      fault_next = 1'b0;

    // Restart delay counter on the slow tick
    delay_next = delay_reg;
    delay_run_next = delay_run_reg;
    if (restart_evt)
    begin
      delay_next = '0;
      delay_run_next = 1'b1;
    end
    else if (delay_run_reg && tick_reg)
    begin
      delay_next = delay_reg + 8'd1;
      if (delay_reg == 8'(hb_seq_pkg::RESTART_DELAY_TICKS - 1))
        delay_run_next = 1'b0;
    end

    // Settling one-shot, started only by the reset release
    settle_next = settle_reg;
    settle_run_next = settle_run_reg;
    if (settle_run_reg && tick_reg)
    begin
      settle_next = settle_reg + 8'd1;
      if (settle_reg == 8'(hb_seq_pkg::SETTLE_TICKS - 1))
        settle_run_next = 1'b0;
    end

    // Oscillator sequence
    state_next = state_reg;
    phase_next = phase_reg;
    case (state_reg)
      ST_STOPPED:
      begin
        phase_next = 1'b0;
        if (delay_run_reg)
          state_next = ST_DELAY;
      end
      ST_DELAY:
      begin
        // Phase cleared so the low side fires first
        phase_next = 1'b0;
        if (!delay_run_reg && running && sense_good)
          state_next = ST_CHARGE;
      end
      ST_CHARGE:
      begin
        if (!running || delay_run_reg)
          state_next = ST_STOPPED;
        else if (cmp_reg.cap_full)
          state_next = ST_DISCHARGE;
      end
      ST_DISCHARGE:
      begin
        if (!running || delay_run_reg)
          state_next = ST_STOPPED;
        else if (cmp_reg.cap_empty)
        begin
          state_next = ST_CHARGE;
          phase_next = !phase_reg;
        end
      end
      default:
        state_next = ST_STOPPED;
    endcase
  end

  // Drive and switch outputs
  always_comb
  begin
    logic charging;
    logic good;
    charging = (state_reg == ST_CHARGE);
    good = delay_run_reg || charging || (state_reg == ST_DISCHARGE);
    // Low side pipelined; high side given an equal pipeline for matching
    low_pipe_next = {low_pipe_reg[hb_seq_pkg::MATCH_DELAY_CYC-2:0], charging && !phase_reg};
    high_pipe_next = {high_pipe_reg[hb_seq_pkg::MATCH_DELAY_CYC-2:0],
      charging && phase_reg && cmp_reg.high_side_ok};
    drv_next.charge_en = charging;
    drv_next.capacitor_discharge_sink = (state_reg == ST_DISCHARGE);
    drv_next.timing_resistor_ground = delay_run_reg;
    // One-shot forces the sink; otherwise comparator and window decide
    drv_next.hysteresis_sink = settle_run_reg
      || (!cmp_reg.sense_above_on && !good);
    // Drives gated again at output so a stop cuts any pipelined pulse
    drv_next.drive_low = low_pipe_reg[hb_seq_pkg::MATCH_DELAY_CYC-1] && charging && running;
    drv_next.drive_high = high_pipe_reg[hb_seq_pkg::MATCH_DELAY_CYC-1] && charging && running
      && cmp_reg.high_side_ok;
  end

  // Wishbone slave, one wait state, unmapped reads return zero
  always_comb
  begin
    ctrl_next = ctrl_reg;
    rdat_next = rdat_reg;
    ack_next = 1'b0;
    if (wb_req)
    begin
      ack_next = 1'b1;
      rdat_next = '0;
      if (I_WB_WE && I_WB_ADR == hb_seq_pkg::ADDR_CTRL && I_WB_SEL[0])
        ctrl_next = {31'h00000000, I_WB_DAT[hb_seq_pkg::CTRL_RUN_BIT]};
      else if (!I_WB_WE && I_WB_ADR == hb_seq_pkg::ADDR_CTRL)
        rdat_next = ctrl_reg;
      else if (!I_WB_WE && I_WB_ADR == hb_seq_pkg::ADDR_STATUS)
      begin
        rdat_next[hb_seq_pkg::ST_FAULT_BIT] = fault_reg;
        rdat_next[hb_seq_pkg::ST_DELAY_BIT] = delay_run_reg;
        rdat_next[hb_seq_pkg::ST_SETTLE_BIT] = settle_run_reg;
        rdat_next[hb_seq_pkg::ST_GOOD_BIT] = sense_good;
        rdat_next[hb_seq_pkg::ST_SINK_BIT] = drv_reg.hysteresis_sink;
        rdat_next[hb_seq_pkg::ST_PHASE_BIT] = phase_reg;
        rdat_next[hb_seq_pkg::ST_DISCH_BIT] = drv_reg.capacitor_discharge_sink;
      end
    end
  end

  // Register all state; reset is a controller restart
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      state_reg <= ST_STOPPED;
      phase_reg <= 1'b0;
      fault_reg <= 1'b0;
      div_reg <= '0;
      tick_reg <= 1'b0;
      delay_reg <= '0;
      delay_run_reg <= 1'b1;
      settle_reg <= '0;
      settle_run_reg <= 1'b1;
      stop_reg <= '0;
      good_prev_reg <= 1'b0;
      run_prev_reg <= 1'b1;
      low_pipe_reg <= '0;
      high_pipe_reg <= '0;
      drv_reg <= '0;
      ctrl_reg <= hb_seq_pkg::CTRL_RESET;
      rdat_reg <= '0;
      ack_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      fault_reg <= fault_next;
      div_reg <= div_next;
      tick_reg <= tick_next;
      delay_reg <= delay_next;
      delay_run_reg <= delay_run_next;
      settle_reg <= settle_next;
      settle_run_reg <= settle_run_next;
      stop_reg <= stop_next;
      good_prev_reg <= good_prev_next;
      run_prev_reg <= run_prev_next;
      low_pipe_reg <= low_pipe_next;
      high_pipe_reg <= high_pipe_next;
      drv_reg <= drv_next;
      ctrl_reg <= ctrl_next;
      rdat_reg <= rdat_next;
      ack_reg <= ack_next;
    end
  end

  // Outputs straight from flops
  assign O_DRV = drv_reg;
  assign O_WB_DAT = rdat_reg;
  assign O_WB_ACK = ack_reg;

endmodule : half_bridge_sequencer

// >>> dv/hb_seq_checker.sv
/*
  Port checker for the half-bridge sequencer.
  Assumes a bind onto the sequencer top, one clock, sync reset.
*/
module hb_seq_checker (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire hb_seq_pkg::cmp_t I_CMP,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic O_WB_ACK,
  input wire hb_seq_pkg::drv_t O_DRV
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  // Bus answers one cycle after a take, pulse only
  a_ack_next: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack late");
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack too long");
  // Discharge is the dead time
  a_dead_time: assert property (O_DRV.capacitor_discharge_sink |-> !O_DRV.drive_low && !O_DRV.drive_high)
    else $error("drive in dead time");
  a_delay_osc: assert property (O_DRV.timing_resistor_ground |-> !O_DRV.charge_en)
    else $error("charge in delay");
  a_delay_drive: assert property (O_DRV.timing_resistor_ground
    |-> !(O_DRV.drive_low || O_DRV.drive_high))
    else $error("drive in delay");
  a_one_side: assert property (!(O_DRV.drive_low && O_DRV.drive_high))
    else $error("both sides on");
  // Sync delay allowed before lockout bites
  a_hs_lock: assert property ((!I_CMP.high_side_ok) [*6] |-> !O_DRV.drive_high)
    else $error("high side without supply");
  a_reset_quiet: assert property ($fell(I_SRST) |-> O_DRV == '0)
    else $error("drive out of reset");
  a_restart_gnd: assert property ($fell(I_SRST)
    |-> ##2 O_DRV.timing_resistor_ground && O_DRV.hysteresis_sink)
    else $error("no restart ground");
  c_ack: cover property (O_WB_ACK);
  c_restart: cover property ($fell(I_SRST));
  c_latch: cover property (I_CMP.sense_above_latch);
  c_high: cover property (O_DRV.drive_high);
endmodule : hb_seq_checker

// >>> dv/hb_front_model.sv
/*
  Analog front end: timing capacitor and threshold comparators.
  Assumes sense levels come from the bench.
*/
module hb_front_model (
  input wire logic i_clock,
  input wire hb_seq_pkg::drv_t i_drv,
  input wire logic i_above_on,
  input wire logic i_above_latch,
  input wire logic i_hs_ok,
  output hb_seq_pkg::cmp_t o_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  int volts = 0; // Steps of capacitor level, 25 is full
  // Slow ramp up, faster sink down, as the real capacitor
  always @(posedge i_clock)
  begin
    if (i_drv.charge_en && volts < 25)
      volts <= volts + 1;
    else if (i_drv.capacitor_discharge_sink)
      volts <= (volts > 5) ? volts - 5 : 0;
  end
  assign o_cmp = {volts >= 25, volts == 0, i_above_on, i_above_latch, i_hs_ok};
endmodule : hb_front_model

// >>> dv/testbench.sv
/*
  Self-checking bench for the half-bridge sequencer.
  Assumes the front-end model and a Wishbone master task.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, srst = 1, cyc = 0, stb = 0, we = 0, ack;
  logic on = 1, latch = 0, hs = 1;
  logic side_m = 1, chg_prev = 0, low_prev = 0, high_prev = 0;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, q, d;
  hb_seq_pkg::cmp_t cmp;
  hb_seq_pkg::drv_t drv;
  int n_fail = 0, n_compared = 0, cycles = 0, ctrl_m = 1, fault_m = 0;
  int h = 0, l = 0, lag = 0, n_low = 0, n_high = 0, st_m = 32'h16;
  always #4 clock = ~clock;
  // Short tick so the restart delay ends within the run
  half_bridge_sequencer #(.TICK_DIV(10)) u_dut (.I_CLOCK(clock), .I_SRST(srst), .I_CMP(cmp), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_DRV(drv));
  hb_front_model u_fe (.i_clock(clock), .i_drv(drv), .i_above_on(on), .i_above_latch(latch),
    .i_hs_ok(hs), .o_cmp(cmp));
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  // Reference of the drive order: side per charge cycle, dead time, lag
  always @(posedge clock)
  begin
    if (srst || drv.timing_resistor_ground)
      side_m = 1'b1;
    else if (drv.charge_en && !chg_prev)
    begin
      lag = 0;
      side_m = !side_m;
    end
    else if (drv.charge_en)
      lag++;
    if (drv.capacitor_discharge_sink)
      check(drv.drive_low || drv.drive_high, 1'b0);
    if ((drv.drive_low && !low_prev) || (drv.drive_high && !high_prev))
    begin
      check(drv.drive_high, side_m);
      check(lag, hb_seq_pkg::MATCH_DELAY_CYC);
    end
    if (drv.drive_low && !low_prev)
      n_low <= n_low + 1;
    if (drv.drive_high && !high_prev)
      n_high <= n_high + 1;
    chg_prev = drv.charge_en;
    low_prev = drv.drive_low;
    high_prev = drv.drive_high;
  end
  // Classic cycle; ack looked at where it is settled
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= v;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'b1);
    check(ack, 1'b1);
    check(n, 2); // Answer one cycle after the take
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Read status, expecting st_m and fault_m; delay, settle and sink on until the last check
  task automatic status;
    repeat (6) @(posedge clock);
    wb(0, hb_seq_pkg::ADDR_STATUS, 4'hf, '0);
    check(q, st_m | fault_m);
  endtask : status
  // Fault set with sense above turn-on, pulse ends
  task automatic trip;
    on <= 1'b1;
    latch <= 1'b1;
    repeat (6) @(posedge clock);
    latch <= 1'b0;
    fault_m = 1;
    status();
    check(drv, 6'h0c);
  endtask : trip
  always @(posedge clock)
  begin
    if (++cycles == 12000)
    begin
      n_fail++;
      summarize();
    end
  end
  initial
  begin
    void'($urandom(42065));
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    check(drv, 6'h0c);
    status();
    wb(0, hb_seq_pkg::ADDR_CTRL, 4'hf, '0);
    check(q, hb_seq_pkg::CTRL_RESET);
    $display("test reset done");
    // Random words and byte enables into control
    repeat (8)
    begin
      d = $urandom;
      wb(1, hb_seq_pkg::ADDR_CTRL, 4'($urandom), d);
      if (sel[0])
        ctrl_m = d[0];
      wb(0, hb_seq_pkg::ADDR_CTRL, 4'hf, '0);
      check(q, ctrl_m);
    end
    wb(1, hb_seq_pkg::ADDR_CTRL, 4'hf, 32'h1);
    wb(1, hb_seq_pkg::ADDR_STATUS, 4'hf, $urandom);
    status();
    wb(0, 8'h08, 4'hf, '0);
    check(q, '0);
    $display("test registers done");
    trip();
    wb(1, hb_seq_pkg::ADDR_CTRL, 4'hf, 32'h3);
    fault_m = 0;
    status();
    trip();
    on <= 1'b0;
    fault_m = 0;
    status();
    trip();
    srst <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    fault_m = 0;
    status();
    $display("test fault done");
    // Oscillator after settle, the restart it causes and the delay
    wait (n_low >= 2);
    @(posedge clock);
    check(n_high, 1);
    check(drv.hysteresis_sink, 1'b0);
    // High-side supply lost: low pulses go on, high ones stop
    hs <= 1'b0;
    repeat (4) @(posedge clock);
    h = n_high;
    l = n_low;
    wait (n_low >= l + 3);
    @(posedge clock);
    check(n_high, h);
    // Sense lost: pulses last for the stop delay, then cease
    on <= 1'b0;
    repeat (2400) @(posedge clock);
    check(drv.hysteresis_sink, 1'b0);
    repeat (120) @(posedge clock);
    check(drv, 6'h08);
    // Sense back: fresh restart delay, low side first again
    on <= 1'b1;
    hs <= 1'b1;
    st_m = 32'h0a;
    status();
    check(drv, 6'h04);
    l = n_low;
    wait (n_low >= l + 1);
    @(posedge clock);
    check(n_low, l + 1);
    $display("test oscillator done");
    summarize();
  end
endmodule : testbench
bind half_bridge_sequencer hb_seq_checker u_chk (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_CMP(I_CMP),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .O_DRV(O_DRV));
